// >>> hw/scm_pkg.sv
// Constants and types shared by the strain converter mode sequencer
// What this block does
// - Single conversion: one sequence, then sleep
// - One-shot off: measure continuously, oscillator always on unless stretched
// - One-shot on: oscillator off until interval expires
// - Two-bit stretch field; zero disables stretching
// - Stretch 1: oscillator per discharge, slow gaps
// - Stretch 2/3: pairs spaced 200 or 300 us
// - Stretched wait equals setting times 100 us
// - Lead field starts oscillator before discharges after slow gaps
// - Stretched single: pair back to back, delay
// - Stretched continuous: no break, oscillator per pair
// - Stretching never adds discharge cycles
// - Sequence interval counts 6.4 ms per step
// - Averaging count sets ratio measurements per sequence
// - Sequence length follows the cycle formula
// - Dummy code gives 0, 2, 4, 16 fakes
// - Sample is 2, 4 or 8 discharges
// - Unstretched cycle time in 2 us steps
package scm_pkg;

    // Clock period of the reference clock
    localparam int CLK_PERIOD_NS    = 50;
    // Unstretched cycle time unit
    localparam int CYCLE_UNIT_NS    = 2000;
    localparam int CYCLE_UNIT_CLKS  = (CYCLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Slow oscillator period, 10 kHz
    localparam int SLOW_TICK_NS     = 100000;
    localparam int SLOW_TICK_CLKS   = SLOW_TICK_NS / CLK_PERIOD_NS;
    // Pair spacing for stretch value 2
    localparam int PAIR2_NS         = 200000;
    localparam int PAIR2_CLKS       = (PAIR2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Pair spacing for stretch value 3 (count is a top parameter)
    localparam int PAIR3_NS         = 300000;
    localparam int PAIR3_CLKS       = (PAIR3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Sequence interval step, 6.4 ms (count is a top parameter)
    localparam int SLOT_NS          = 6400000;
    localparam int SLOT_CLKS        = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Fixed overhead cycles in every sequence (6 + 1)
    localparam logic [15:0] SEQ_OVERHEAD = 16'h0007;
    // Discharges per sample for half, full, quattro
    localparam logic [3:0]  CPS_HALF     = 4'h2;
    localparam logic [3:0]  CPS_FULL     = 4'h4;
    localparam logic [3:0]  CPS_QUATTRO  = 4'h8;
    // Fake measurement counts per dummy code
    localparam logic [4:0]  FAKE_CODE0   = 5'h00;
    localparam logic [4:0]  FAKE_CODE1   = 5'h02;
    localparam logic [4:0]  FAKE_CODE2   = 5'h04;
    localparam logic [4:0]  FAKE_CODE3   = 5'h10;
    // Stretch field codes
    localparam logic [1:0]  STRETCH_OFF  = 2'h0;
    localparam logic [1:0]  STRETCH_ONE  = 2'h1;
    localparam logic [1:0]  STRETCH_200  = 2'h2;

    // Bridge kind
    typedef enum logic [1:0] {
        BRIDGE_HALF    = 2'h0,
        BRIDGE_FULL    = 2'h1,
        BRIDGE_QUATTRO = 2'h2
    } scm_bridge_type;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        S_SLEEP = 5'b00001,
        S_DISCH = 5'b00010,
        S_SPACE = 5'b00100,
        S_GAP   = 5'b01000,
        S_DONE  = 5'b10000
    } scm_state_type;

    // Configuration written by software
    typedef struct packed {
        logic           single_conv;   // One-shot select
        logic [1:0]     stretch;       // Stretch field
        logic [9:0]     cycle_time;    // Interval setting
        logic [2:0]     osc_lead;      // Oscillator lead, in slow ticks
        logic [7:0]     seq_interval;  // Sequence interval, in slots
        logic [9:0]     avg_count;     // Averaging count
        scm_bridge_type bridge;        // Bridge kind
        logic [1:0]     dummy_code;    // Fake measurement code
    } scm_cfg_type;

endpackage : scm_pkg

// >>> hw/scm_sequencer.sv
// Mode sequencer for the discharge-time strain converter
`timescale 1ns/1ps
module scm_sequencer
#(
    parameter int PAIR3_CYCLES = scm_pkg::PAIR3_CLKS,  // 300 us pair spacing
    parameter int SLOT_CYCLES  = scm_pkg::SLOT_CLKS    // 6.4 ms interval step
)
(
    // Clock and reset
    input  wire logic                 REF_CLK_I,
    input  wire logic                 RESET_I,
    // Configuration
    input  wire logic                 ENABLE_I,
    input  wire scm_pkg::scm_cfg_type CFG_I,
    // Discharge end from the comparator
    input  wire logic                 DISCH_END_I,
    // Sequencer outputs
    output logic                      FAST_OSC_EN_O,
    output logic                      DISCH_START_O,
    output logic                      MEAS_DONE_O,
    output logic                      SLEEP_O,
    output logic [15:0]               SEQ_CYCLE_O
);
    import scm_pkg::*;

    // State and counters
    scm_state_type state_reg,     state_next;     // Sequencer state
    logic [15:0]   cyc_reg,       cyc_next;       // Discharge index in sequence
    logic [16:0]   fast_reg,      fast_next;      // Clocks since discharge start
    logic [10:0]   tick_reg,      tick_next;      // Slow tick divider
    logic [9:0]    gap_reg,       gap_next;       // Slow ticks left in gap
    logic [22:0]   slot_clk_reg,  slot_clk_next;  // Clocks within interval slot
    logic [7:0]    slot_num_reg,  slot_num_next;  // Slots since sequence start
    logic          start_reg,     start_next;     // Discharge start pulse
    logic          done_reg,      done_next;      // Completion pulse
    logic          osc_reg,       osc_next;       // Fast oscillator enable

    // Derived configuration
    logic [3:0]    cycles_per_sample;             // Discharges per sample
    logic [4:0]    fake_count;                    // Fake measurements
    logic [15:0]   seq_total;                     // Discharges per sequence
    logic          stretched;                     // Any stretch mode
    logic          slow_tick;                     // 10 kHz tick
    logic          slot_due;                      // Interval expired
    logic [16:0]   space_limit;                   // Fast-timed spacing

    // Sample size and fake table
    always_comb
    begin
        case (CFG_I.bridge)
            BRIDGE_FULL:    cycles_per_sample = CPS_FULL;
            BRIDGE_QUATTRO: cycles_per_sample = CPS_QUATTRO;
            default:        cycles_per_sample = CPS_HALF;
        endcase
        case (CFG_I.dummy_code)
            2'h1:    fake_count = FAKE_CODE1;
            2'h2:    fake_count = FAKE_CODE2;
            2'h3:    fake_count = FAKE_CODE3;
            default: fake_count = FAKE_CODE0;
        endcase
    end

    // Sequence length, factors widened first; stretching leaves it untouched
    assign seq_total = (16'(CFG_I.avg_count) * 16'(cycles_per_sample))
                       + SEQ_OVERHEAD + {11'h000, fake_count};
    assign stretched = (CFG_I.stretch != STRETCH_OFF);
    assign slow_tick = (tick_reg == 11'(SLOW_TICK_CLKS - 1));
    assign slot_due  = (slot_num_reg >= CFG_I.seq_interval);

    // Spacing timed on the fast clock
    always_comb
    begin
        if (!stretched)
        begin
            // Cycle time in 2 us steps
            space_limit = 17'(CFG_I.cycle_time * CYCLE_UNIT_CLKS);
        end
        else if (CFG_I.stretch == STRETCH_200)
        begin
            space_limit = 17'(PAIR2_CLKS);
        end
        else
        begin
            space_limit = 17'(PAIR3_CYCLES);
        end
    end

    // Next-state logic for the sequencer
    always_comb
    begin
        state_next    = state_reg;
        cyc_next      = cyc_reg;
        fast_next     = (fast_reg == 17'h1ffff) ? fast_reg : fast_reg + 17'h00001;
        tick_next     = slow_tick ? 11'h000 : tick_reg + 11'h001;
        gap_next      = gap_reg;
        start_next    = 1'b0;
        done_next     = 1'b0;
        // Slot counter runs from each sequence start out of sleep
        if (slot_clk_reg >= 23'(SLOT_CYCLES - 1))
        begin
            slot_clk_next = 23'h000000;
            slot_num_next = (slot_num_reg == 8'hff) ? slot_num_reg
                                                    : slot_num_reg + 8'h01;
        end
        else
        begin
            slot_clk_next = slot_clk_reg + 23'h000001;
            slot_num_next = slot_num_reg;
        end
        case (state_reg)
            S_SLEEP:
            begin
                // Continuous starts at once; single waits for the slot
                if (ENABLE_I && (!CFG_I.single_conv || slot_due))
                begin
                    state_next    = S_DISCH;
                    start_next    = 1'b1;
                    cyc_next      = 16'h0000;
                    fast_next     = 17'h00000;
                    slot_clk_next = 23'h000000;
                    slot_num_next = 8'h00;
                end
            end
            S_DISCH:
            begin
                if (DISCH_END_I)
                begin
                    cyc_next = cyc_reg + 16'h0001;
                    if (cyc_reg >= seq_total - 16'h0001)
                    begin
                        // Last discharge closes the sequence
                        state_next = S_DONE;
                        done_next  = 1'b1;
                    end
                    else if (!stretched ||
                             (CFG_I.stretch != STRETCH_ONE && !cyc_reg[0]))
                    begin
                        // Every unstretched discharge, or the second of a pair, follows closely
                        state_next = S_SPACE;
                    end
                    else
                    begin
                        // Long gap counted on the slow clock
                        state_next = S_GAP;
                        gap_next   = CFG_I.cycle_time;
                        tick_next  = 11'h000;
                    end
                end
            end
            S_SPACE:
            begin
                // Start to start spacing on the fast clock
                if (fast_reg + 17'h00001 >= space_limit)
                begin
                    state_next = S_DISCH;
                    start_next = 1'b1;
                    fast_next  = 17'h00000;
                end
            end
            S_GAP:
            begin
                if (slow_tick)
                begin
                    if (gap_reg <= 10'h001)
                    begin
                        state_next = S_DISCH;
                        start_next = 1'b1;
                        fast_next  = 17'h00000;
                        gap_next   = 10'h000;
                    end
                    else
                    begin
                        gap_next = gap_reg - 10'h001;
                    end
                end
            end
            S_DONE:
            begin
                cyc_next      = 16'h0000;
                slot_clk_next = slot_clk_reg;
                slot_num_next = slot_num_reg;
                if (CFG_I.single_conv || !ENABLE_I)
                begin
                    state_next = S_SLEEP;
                end
                else if (stretched)
                begin
                    // No sequence break, only the usual gap
                    state_next = S_GAP;
                    gap_next   = CFG_I.cycle_time;
                    tick_next  = 11'h000;
                end
                else
                begin
                    state_next = S_SPACE;
                end
            end
            default:
            begin
                state_next = S_SLEEP;
            end
        endcase
        // Oscillator follows the next state
        if (!ENABLE_I && state_next == S_SLEEP)
        begin
            osc_next = 1'b0;
        end
        else if (!CFG_I.single_conv && !stretched)
        begin
            osc_next = 1'b1;
        end
        else
        begin
            case (state_next)
                S_DISCH, S_SPACE, S_DONE: osc_next = 1'b1;
                // Warm-up lead ahead of the coming discharge
                S_GAP:   osc_next = (gap_next <= {7'h00, CFG_I.osc_lead});
                default: osc_next = 1'b0;
            endcase
        end
    end

    // Register stage, synchronous reset
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            state_reg    <= S_SLEEP;
            cyc_reg      <= 16'h0000;
            fast_reg     <= 17'h00000;
            tick_reg     <= 11'h000;
            gap_reg      <= 10'h000;
            slot_clk_reg <= 23'h000000;
            slot_num_reg <= 8'hff;
            start_reg    <= 1'b0;
            done_reg     <= 1'b0;
            osc_reg      <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            cyc_reg      <= cyc_next;
            fast_reg     <= fast_next;
            tick_reg     <= tick_next;
            gap_reg      <= gap_next;
            slot_clk_reg <= slot_clk_next;
            slot_num_reg <= slot_num_next;
            start_reg    <= start_next;
            done_reg     <= done_next;
            osc_reg      <= osc_next;
        end
    end

    // Outputs straight from flip-flops, SLEEP_O decoded from state_reg
    assign FAST_OSC_EN_O = osc_reg;
    assign DISCH_START_O = start_reg;
    assign MEAS_DONE_O   = done_reg;
    assign SLEEP_O       = (state_reg == S_SLEEP);
    assign SEQ_CYCLE_O   = cyc_reg;

endmodule : scm_sequencer

// >>> testbench/scm_sequencer_sva.sv
// Port-level assertion checker for the mode sequencer
`timescale 1ns/1ps
module scm_sequencer_sva
    import scm_pkg::*;
#(
    parameter int PAIR3_CYCLES = scm_pkg::PAIR3_CLKS  // Second-of-pair spacing, stretch 3
)
(
    input wire logic                 REF_CLK_I,
    input wire logic                 RESET_I,
    input wire logic                 ENABLE_I,
    input wire scm_pkg::scm_cfg_type CFG_I,
    input wire logic                 DISCH_END_I,
    input wire logic                 FAST_OSC_EN_O,
    input wire logic                 DISCH_START_O,
    input wire logic                 MEAS_DONE_O,
    input wire logic                 SLEEP_O,
    input wire logic [15:0]          SEQ_CYCLE_O
);
    logic [15:0] since_reg;   // Clocks since the last start
    logic [15:0] since_next;
    logic        seen_reg;    // Start seen since sleep; first start has no spacing
    logic        seen_next;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);
    // Spacing counter restarts at every start pulse
    always_comb
    begin
        since_next = DISCH_START_O ? 16'h0001 : since_reg + 16'h0001;
        seen_next  = (seen_reg | DISCH_START_O) & ~SLEEP_O;
    end
    // Register only
    always_ff @(posedge REF_CLK_I)
    begin
        since_reg <= RESET_I ? 16'h0000 : since_next;
        seen_reg  <= RESET_I ? 1'b0 : seen_next;
    end
    a_reset_idle: assert property (disable iff (1'b0) RESET_I |=> SLEEP_O && !FAST_OSC_EN_O
        && SEQ_CYCLE_O == 16'h0000) else $error("idle state wrong after reset");
    a_start_osc_on: assert property (DISCH_START_O |-> FAST_OSC_EN_O)
        else $error("discharge started with oscillator off");
    a_cont_osc_on: assert property (
        !CFG_I.single_conv && CFG_I.stretch == 2'h0 && !SLEEP_O |-> FAST_OSC_EN_O)
        else $error("oscillator dropped in continuous mode");
    a_sleep_osc_off: assert property (SLEEP_O && CFG_I.single_conv |-> !FAST_OSC_EN_O)
        else $error("oscillator on in single-mode sleep");
    a_wake_start: assert property (SLEEP_O && ENABLE_I && !CFG_I.single_conv
        |=> DISCH_START_O) else $error("continuous wake did not start");
    a_done_single: assert property (MEAS_DONE_O |=> !MEAS_DONE_O)
        else $error("completion pulse longer than one cycle");
    a_done_after_end: assert property (MEAS_DONE_O |-> $past(DISCH_END_I))
        else $error("completion without a discharge end");
    a_done_sleep: assert property (MEAS_DONE_O && CFG_I.single_conv |-> ##[1:2] SLEEP_O)
        else $error("single mode did not sleep after sequence");
    a_unstr_space: assert property (DISCH_START_O && seen_reg && CFG_I.stretch == 2'h0
        |-> since_reg == 16'(CFG_I.cycle_time * 40)) else $error("unstretched spacing");
    a_pair_space: assert property (
        DISCH_START_O && CFG_I.stretch[1] && SEQ_CYCLE_O[0]
        |-> since_reg == 16'(CFG_I.stretch[0] ? PAIR3_CYCLES : PAIR2_CLKS))
        else $error("pair spacing wrong");
    // Starts after a slow gap; long settings would overflow the spacing counter
    a_gap_space: assert property (
        DISCH_START_O && seen_reg && CFG_I.stretch != 2'h0 && CFG_I.cycle_time < 10'h020
        && !(CFG_I.stretch[1] && SEQ_CYCLE_O[0])
        |-> since_reg >= 16'(CFG_I.cycle_time * SLOW_TICK_CLKS))
        else $error("stretched gap too short");
    c_single_done: cover property (MEAS_DONE_O && CFG_I.single_conv);
    c_stretch_cont: cover property (MEAS_DONE_O && !CFG_I.single_conv && CFG_I.stretch != 2'h0);
    c_stretch_one: cover property (DISCH_START_O && CFG_I.stretch == 2'h1);
    c_stretch_three: cover property (DISCH_START_O && CFG_I.stretch == 2'h3);
endmodule : scm_sequencer_sva
bind scm_sequencer scm_sequencer_sva #(.PAIR3_CYCLES(PAIR3_CYCLES)) scm_sequencer_sva_inst (
    .REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .ENABLE_I(ENABLE_I), .CFG_I(CFG_I),
    .DISCH_END_I(DISCH_END_I), .FAST_OSC_EN_O(FAST_OSC_EN_O), .DISCH_START_O(DISCH_START_O),
    .MEAS_DONE_O(MEAS_DONE_O), .SLEEP_O(SLEEP_O), .SEQ_CYCLE_O(SEQ_CYCLE_O));

// >>> testbench/scm_sequencer_bench.sv
// Self-checking bench for the mode sequencer
`timescale 1ns/1ps
module scm_sequencer_bench;
    import scm_pkg::*;
    logic        clk = 1'b0;   // 20 MHz reference
    logic        rst = 1'b1;   // Synchronous reset
    logic        enable = 1'b0;
    scm_cfg_type cfg = '0;
    logic        disch_end = 1'b0;
    logic        osc, start, done, sleep;
    logic [15:0] seq_cycle;
    int          failures = 0, samples_checked = 0, cyc = 0, t0 = 0, resp_cnt = 0;
    always #25 clk = ~clk;
    scm_sequencer #(.PAIR3_CYCLES(60), .SLOT_CYCLES(200)) scm_sequencer_inst (
        .REF_CLK_I(clk), .RESET_I(rst), .ENABLE_I(enable), .CFG_I(cfg),
        .DISCH_END_I(disch_end), .FAST_OSC_EN_O(osc), .DISCH_START_O(start),
        .MEAS_DONE_O(done), .SLEEP_O(sleep), .SEQ_CYCLE_O(seq_cycle));
    // Comparator stand-in: end pulse five clocks after each start
    always @(negedge clk)
    begin
        cyc <= cyc + 1;
        disch_end <= (resp_cnt == 1);
        if (start === 1'b1)
            resp_cnt <= 5;
        else if (resp_cnt != 0)
            resp_cnt <= resp_cnt - 1;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task automatic set_cfg(input logic sc, input logic [1:0] st, input logic [9:0] ct,
                           input scm_bridge_type br, input logic [1:0] dc, input logic [7:0] si);
        cfg = '{sc, st, ct, 3'h0, si, 10'h001, br, dc};
        enable <= 1'b1;
    endtask : set_cfg
    // Counts starts until completion; records first spacing and any oscillator gap
    task automatic run_seq(input int n_exp, input int gap_exp, input logic off_exp,
                           input bit drop);
        int n, t1, k;
        logic off;
        n = 0;
        t1 = 0;
        off = 1'b0;
        for (k = 0; k < 60000; k++)
        begin
            @(negedge clk);
            if (done === 1'b1)
                break;
            if (osc !== 1'b1 && n > 0)
                off = 1'b1;
            if (start === 1'b1)
            begin
                n++;
                if (n == 1)
                    t0 = cyc;
                if (n == 2)
                    t1 = cyc;
                if (drop)
                    enable <= 1'b0;
            end
        end
        if (k == 60000)
        begin
            failures++;
            tally_and_finish();
        end
        check("starts", n, n_exp);
        if (gap_exp != 0)
            check("spacing", t1 - t0, gap_exp);
        check("osc gap", off, off_exp);
    endtask : run_seq
    task automatic t_continuous();
        set_cfg(1'b0, 2'h0, 10'h002, BRIDGE_HALF, 2'h2, 8'h00);
        run_seq(13, 80, 1'b0, 1'b0);
        run_seq(13, 80, 1'b0, 1'b1);
        repeat (3) @(negedge clk);
        check("sleep", sleep, 1);
        $display("continuous test done");
    endtask : t_continuous
    task automatic t_single();
        int k;
        set_cfg(1'b1, 2'h0, 10'h001, BRIDGE_FULL, 2'h3, 8'h0a);
        run_seq(27, 40, 1'b0, 1'b0);
        repeat (3) @(negedge clk);
        check("sleep", sleep, 1);
        check("osc", osc, 0);
        for (k = 0; k < 3000 && start !== 1'b1; k++)
            @(negedge clk);
        check("slot", (cyc - t0 >= 2000) && (cyc - t0 <= 2005), 1);
        enable <= 1'b0;
        run_seq(26, 40, 1'b0, 1'b0);
        $display("single test done");
    endtask : t_single
    task automatic t_stretch();
        int st;
        for (st = 1; st < 4; st++)
        begin
            // Stretch 3 runs continuous with one tick of lead, the others single
            set_cfg(st != 3, 2'(st), 10'h001, st == 3 ? BRIDGE_QUATTRO : BRIDGE_HALF,
                    st == 1 ? 2'h1 : 2'h0, 8'h00);
            cfg.osc_lead = (st == 3) ? 3'h1 : 3'h0;
            if (st == 3)
                run_seq(15, 60, 1'b0, 1'b0);
            run_seq(st == 3 ? 15 : (st == 1 ? 11 : 9), st == 1 ? 0 : (st == 2 ? 4000 : 60),
                    st != 3, 1'b1);
            repeat (3) @(negedge clk);
            check("sleep", sleep, 1);
        end
        $display("stretch test done");
    endtask : t_stretch
    initial
    begin
        repeat (6) @(negedge clk);
        rst <= 1'b0;
        t_continuous();
        t_single();
        t_stretch();
        tally_and_finish();
    end
endmodule : scm_sequencer_bench
